// ---- tb_usb_endpoint_rx_state.sv ----
/* Self-checking bench: APB register access plus host traffic.
   Assumes the host model and checker files are compiled first. */
module tb_usb_endpoint_rx_state
  import usb_ep_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic                  busReset, rxEnd, rxIsSetup, rxDataPid, rxError;
  logic                  replyValid, epIrq, xferIrq, lastErr;
  logic [ADDR_W-1:0]     paddr;
  logic [DATA_W-1:0]     pwdata, prdata, rdata;
  logic [DEV_ADDR_W-1:0] rxDevAddr;
  logic [EP_IDX_W-1:0]   rxEpNum;
  reply_t                replyCode;
  int                    nErrors, cmpCount;

  usb_endpoint_rx_state DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busReset(busReset), .rxEnd(rxEnd), .rxIsSetup(rxIsSetup),
    .rxDevAddr(rxDevAddr), .rxEpNum(rxEpNum), .rxDataPid(rxDataPid), .rxError(rxError),
    .replyValid(replyValid), .replyCode(replyCode), .epIrq(epIrq), .xferIrq(xferIrq));
  usb_host_model host (.clk(clk), .rxEnd(rxEnd), .rxIsSetup(rxIsSetup),
    .rxDevAddr(rxDevAddr), .rxEpNum(rxEpNum), .rxDataPid(rxDataPid), .rxError(rxError));

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude();
    if (nErrors == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic check(input string nm, input logic [DATA_W-1:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      nErrors++;
      conclude();
    end else begin
      rdata = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(1'b0, a, 32'h0);
    check("register", rdata, e);
  endtask : rd

  // Host reception, then reply check
  task automatic xfer(input logic s, input logic [DEV_ADDR_W-1:0] dv,
                      input logic [EP_IDX_W-1:0] ep, input logic pid, er, input logic [1:0] c);
    host.send(s, dv, ep, pid, er);
    @(negedge clk);
    check("reply valid", replyValid, c != 2'h0);
    check("reply code", replyCode, c);
  endtask : xfer

  // Main sequence
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    busReset = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < EP_COUNT; i++) begin
      rd(ADDR_W'(4 * i), 32'h0);
    end
    rd(8'h48, 32'h0);
    check("slave error", lastErr, 1'b1);
    wr(FADDR_ADDR, 32'h85);
    rd(FADDR_ADDR, 32'h85);
    wr(8'h00, 32'hB280);
    rd(8'h00, 32'h3200);
    wr(8'h04, 32'hB081);
    rd(8'h04, 32'h3001);
    xfer(1'b1, 7'h05, 4'h0, 1'b0, 1'b0, REPLY_ACK);
    rd(8'h00, 32'hEA00);
    check("ep irq", epIrq, 1'b1);
    check("transfer irq", xferIrq, 1'b0);
    wr(8'h00, 32'h0280);
    rd(8'h00, 32'h6A00);
    check("ep irq", epIrq, 1'b0);
    xfer(1'b1, 7'h05, 4'h0, 1'b0, 1'b0, 2'h0);
    rd(8'h00, 32'h2A00);
    wr(8'h00, 32'h9280);
    xfer(1'b1, 7'h05, 4'h0, 1'b0, 1'b0, REPLY_ACK);
    wr(8'h00, 32'h9280);
    xfer(1'b0, 7'h05, 4'h0, 1'b1, 1'b0, REPLY_ACK);
    rd(8'h00, 32'hAA00);
    xfer(1'b0, 7'h05, 4'h1, 1'b1, 1'b0, REPLY_ACK);
    rd(8'h04, 32'h3001);
    xfer(1'b0, 7'h05, 4'h1, 1'b0, 1'b0, REPLY_ACK);
    rd(8'h04, 32'hE001);
    xfer(1'b0, 7'h05, 4'h1, 1'b1, 1'b0, REPLY_NAK);
    wr(8'h04, 32'hC081);
    rd(8'h04, 32'hA001);
    wr(8'h04, 32'h9081);
    rd(8'h04, 32'hB001);
    xfer(1'b0, 7'h05, 4'h1, 1'b0, 1'b1, 2'h0);
    xfer(1'b0, 7'h06, 4'h1, 1'b0, 1'b0, 2'h0);
    rd(STAT_ADDR, 32'h010);
    wr(FADDR_ADDR, 32'h05);
    xfer(1'b0, 7'h05, 4'h1, 1'b0, 1'b0, 2'h0);
    wr(FADDR_ADDR, 32'h85);
    wr(8'h04, 32'hA081);
    xfer(1'b0, 7'h05, 4'h1, 1'b0, 1'b0, REPLY_STALL);
    rd(STAT_ADDR, 32'h113);
    wr(CTRL_ADDR, 32'h8000);
    @(negedge clk);
    check("transfer irq", xferIrq, 1'b1);
    rd(CTRL_ADDR, 32'h8000);
    wr(8'h08, 32'hB482);
    xfer(1'b0, 7'h05, 4'h2, 1'b0, 1'b0, 2'h0);
    rd(8'h08, 32'hF402);
    wr(CTRL_ADDR, 32'h8001);
    rd(8'h00, 32'h8000);
    wr(CTRL_ADDR, 32'h0);
    wr(8'h04, 32'h9081);
    rd(8'h04, 32'h9001);
    @(posedge clk);
    busReset <= 1'b1;
    xfer(1'b0, 7'h05, 4'h1, 1'b0, 1'b0, 2'h0);
    @(posedge clk);
    busReset <= 1'b0;
    rd(8'h04, 32'h8000);
    rd(8'h08, 32'h8000);
    conclude();
  end
endmodule : tb_usb_endpoint_rx_state

bind usb_endpoint_rx_state usb_endpoint_rx_state_checker chk (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .busReset(busReset),
  .rxEnd(rxEnd), .rxError(rxError), .replyValid(replyValid), .replyCode(replyCode),
  .epIrq(epIrq), .xferIrq(xferIrq));

// ---- usb_endpoint_rx_state.sv ----
/*
  Endpoint control and status registers, receive side, with APB access.
  Assumes the link engine reports each finished OUT/SETUP data phase as a
  one-cycle rxEnd pulse with token and data fields, synchronous to clk.
*/
module usb_endpoint_rx_state
  import usb_ep_rx_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [DATA_W-1:0]     pwdata,
  output logic      [DATA_W-1:0]     prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  busReset,
  input  wire logic                  rxEnd,
  input  wire logic                  rxIsSetup,
  input  wire logic [DEV_ADDR_W-1:0] rxDevAddr,
  input  wire logic [EP_IDX_W-1:0]   rxEpNum,
  input  wire logic                  rxDataPid,
  input  wire logic                  rxError,
  output logic                       replyValid,
  output reply_t                     replyCode,
  output logic                       epIrq,
  output logic                       xferIrq
);

  // Whole module state
  typedef struct packed {
    ep_reg_t [EP_COUNT-1:0] ep;
    logic [DEV_ADDR_W-1:0]  devAddr;
    logic                   funcEn;
    logic                   forceRst;
    logic                   irqMask;
    logic                   lastHit;
    logic [EP_IDX_W-1:0]    lastEp;
    reply_t                 lastReply;
    logic [DATA_W-1:0]      rdata;
    logic                   ready;
    logic                   slvErr;
    logic                   replyValid;
    reply_t                 replyCode;
    logic                   epIrq;
    logic                   xferIrq;
  } state_t;

  state_t st;
  state_t next_st;

  // Address decode helpers
  function automatic logic isEpAddr(input logic [ADDR_W-1:0] a);
    return (a[WORD_LSB_W-1:0] == '0) && (a <= EP_LAST_ADDR);
  endfunction : isEpAddr

  function automatic logic [EP_IDX_W-1:0] epIdxOf(
    input logic [ADDR_W-1:0] a);
    return a[WORD_LSB_W +: EP_IDX_W];
  endfunction : epIdxOf

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return isEpAddr(a) || (a == CTRL_ADDR) || (a == STAT_ADDR)
           || (a == FADDR_ADDR);
  endfunction : isMapped

  // Software write of one endpoint word
  function automatic ep_reg_t swWrite(input ep_reg_t cur,
                                      input ep_reg_t w);
    ep_reg_t r;
    // Done flags: 0 clears, 1 keeps
    r = (cur & ~EP_W0C_MASK) | (cur & w & EP_W0C_MASK);
    // Toggle bits: 1 inverts, 0 keeps
    r = r ^ (w & EP_TOG_MASK);
    // Plain read/write fields
    r = (r & ~EP_RW_MASK) | (w & EP_RW_MASK);
    return r;
  endfunction : swWrite

  // Handshake answer for a reception on one endpoint
  function automatic reply_t replyFor(input ep_reg_t cur,
                                      input logic    setup,
                                      input logic    err);
    logic [1:0] hs;
    logic [1:0] cat;
    reply_t     r;
    hs  = cur[RX_HS_HI:RX_HS_LO];
    cat = cur[CAT_HI:CAT_LO];
    r   = REPLY_NONE;
    if (err) begin
      r = REPLY_NONE;
    end else if (setup) begin
      // SETUP: only control endpoints, never NAK or STALL answer
      if (cat == CAT_CONTROL && (hs == HS_VALID || hs == HS_STALL)) begin
        r = REPLY_ACK;
      end
    end else if (cat != CAT_ISO) begin
      unique case (hs)
        HS_DISABLED: r = REPLY_NONE;
        HS_STALL:    r = REPLY_STALL;
        HS_NAK:      r = REPLY_NAK;
        HS_VALID:    r = REPLY_ACK;
      endcase
    end
    return r;
  endfunction : replyFor

  // Hardware update of one endpoint after a reception
  function automatic ep_reg_t rxUpdate(input ep_reg_t cur,
                                       input ep_reg_t e,
                                       input logic    setup,
                                       input logic    pid,
                                       input logic    err);
    ep_reg_t r;
    logic    ctl;
    logic    iso;
    logic    wantPid;
    logic    good;
    r      = e;
    ctl    = cur[CAT_HI:CAT_LO] == CAT_CONTROL;
    iso    = cur[CAT_HI:CAT_LO] == CAT_ISO;
    wantPid = setup ? 1'b0 : cur[RX_TOG_BIT];
    good    = (replyFor(cur, setup, err) == REPLY_ACK) && (pid == wantPid);
    if (setup && ctl) begin
      r[RX_TOG_BIT] = 1'b0;
    end
    if (iso && !setup) begin
      if (cur[RX_HS_HI:RX_HS_LO] == HS_VALID) begin
        // Buffer swap with no handshake
        r[RX_TOG_BIT] = ~e[RX_TOG_BIT];
        if (!err) begin
          r[RX_DONE_BIT] = 1'b1;
        end
      end
    end else if (good) begin
      r[RX_TOG_BIT]  = ~wantPid;
      r[RX_DONE_BIT] = 1'b1;
      r[RX_HS_HI:RX_HS_LO] = HS_NAK;
      // Setup flag only moves while the done flag was clear
      if (ctl && !cur[RX_DONE_BIT]) begin
        r[SETUP_BIT] = setup;
      end
    end
    return r;
  endfunction : rxUpdate

  // Token matcher over the endpoint address fields
  usb_ep_match_if match ();

  usb_ep_token_match u_match (
    .bus (match)
  );

  genvar g;
  generate
    for (g = 0; g < EP_COUNT; g++) begin : g_addr
      assign match.epAddr[g] = st.ep[g][EP_ADDR_HI:EP_ADDR_LO];
    end
  endgenerate

  // Token fields to the matcher
  assign match.tokEp   = rxEpNum;
  assign match.tokDev  = rxDevAddr;
  assign match.devAddr = st.devAddr;
  assign match.funcEn  = st.funcEn;

  logic                    access;
  logic                    wrTake;
  logic                    resetting;
  logic                    rxTake;
  ep_reg_t                 hitReg;
  reply_t                  reply;
  logic [DATA_W-1:0]       rdWord;
  logic [EP_COUNT-1:0]     doneVec;

  // Read mux
  always_comb begin
    rdWord = '0;
    if (isEpAddr(paddr)) begin
      rdWord[REG_W-1:0] = st.ep[epIdxOf(paddr)];
    end else if (paddr == CTRL_ADDR) begin
      rdWord[CTRL_FORCE_BIT] = st.forceRst;
      rdWord[CTRL_MASK_BIT]  = st.irqMask;
    end else if (paddr == STAT_ADDR) begin
      rdWord[STAT_REPLY_LO +: $bits(reply_t)] = st.lastReply;
      rdWord[STAT_EP_LO +: EP_IDX_W]  = st.lastEp;
      rdWord[STAT_HIT_BIT]            = st.lastHit;
    end else if (paddr == FADDR_ADDR) begin
      rdWord[FUNC_EN_BIT]           = st.funcEn;
      rdWord[DEV_ADDR_W-1:0]        = st.devAddr;
    end
  end

  // Next state
  always_comb begin
    next_st = st;

    // APB: one wait state, write lands when pready is seen
    access    = psel && penable && !st.ready;
    wrTake    = psel && penable && pwrite && st.ready;
    resetting = busReset || st.forceRst;
    rxTake    = rxEnd && match.hit && !resetting;
    hitReg    = st.ep[match.hitIdx];
    reply     = replyFor(hitReg, rxIsSetup, rxError);

    next_st.ready  = access;
    next_st.slvErr = access && !isMapped(paddr);
    next_st.rdata  = (access && !pwrite) ? rdWord : '0;

    // Control and function address registers
    if (wrTake && paddr == CTRL_ADDR) begin
      next_st.forceRst = pwdata[CTRL_FORCE_BIT];
      next_st.irqMask  = pwdata[CTRL_MASK_BIT];
    end
    if (wrTake && paddr == FADDR_ADDR) begin
      next_st.funcEn  = pwdata[FUNC_EN_BIT];
      next_st.devAddr = pwdata[DEV_ADDR_W-1:0];
    end

    // Endpoint registers: software first, then hardware
    for (int i = 0; i < EP_COUNT; i++) begin
      if (wrTake && isEpAddr(paddr)
          && epIdxOf(paddr) == EP_IDX_W'(i)) begin
        next_st.ep[i] = swWrite(st.ep[i], pwdata[REG_W-1:0]);
      end
      if (rxTake && match.hitIdx == EP_IDX_W'(i)) begin
        next_st.ep[i] = rxUpdate(st.ep[i], next_st.ep[i], rxIsSetup,
                                 rxDataPid, rxError);
      end
      if (resetting) begin
        next_st.ep[i] = next_st.ep[i] & EP_KEEP_MASK;
      end
      doneVec[i] = next_st.ep[i][RX_DONE_BIT];
    end

    // Handshake answer toward the link
    next_st.replyValid = rxTake && (reply != REPLY_NONE);
    next_st.replyCode  = rxTake ? reply : REPLY_NONE;

    // Last transaction seen, for software
    if (rxEnd) begin
      next_st.lastHit   = rxTake;
      next_st.lastEp    = rxEpNum;
      next_st.lastReply = rxTake ? reply : REPLY_NONE;
    end

    // Interrupt conditions follow the rx done flags; transfer condition also needs irqMask
    next_st.epIrq   = |doneVec;
    next_st.xferIrq = (|doneVec) && next_st.irqMask;
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign prdata     = st.rdata;
  assign pready     = st.ready;
  assign pslverr    = st.slvErr;
  assign replyValid = st.replyValid;
  assign replyCode  = st.replyCode;
  assign epIrq      = st.epIrq;
  assign xferIrq    = st.xferIrq;

endmodule : usb_endpoint_rx_state

// ---- usb_endpoint_rx_state_checker.sv ----
/* Port assertions for the endpoint receive block.
   Assumes a bind to usb_endpoint_rx_state, one clock domain. */
module usb_endpoint_rx_state_checker
  import usb_ep_rx_pkg::*;
(
  input wire logic   clk,
  input wire logic   resetn,
  input wire logic   psel,
  input wire logic   penable,
  input wire logic   pready,
  input wire logic   pslverr,
  input wire logic   busReset,
  input wire logic   rxEnd,
  input wire logic   rxError,
  input wire logic   replyValid,
  input wire reply_t replyCode,
  input wire logic   epIrq,
  input wire logic   xferIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Bus answer timing
  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error alone");
  // Reception replies
  property p_err_silent;
    rxEnd && rxError |=> !replyValid;
  endproperty
  a_err_silent: assert property (p_err_silent) else $error("reply on error");
  property p_no_token;
    !rxEnd |=> !replyValid;
  endproperty
  a_no_token: assert property (p_no_token) else $error("reply unasked");
  property p_reset_blocks;
    rxEnd && busReset |=> !replyValid;
  endproperty
  a_reset_blocks: assert property (p_reset_blocks) else $error("reply in reset");
  property p_code;
    replyValid |-> replyCode inside {REPLY_ACK, REPLY_NAK, REPLY_STALL};
  endproperty
  a_code: assert property (p_code) else $error("bad reply code");
  // Interrupt levels
  property p_done_cause;
    $rose(epIrq) |-> $past(rxEnd);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without token");
  property p_xfer_sub;
    xferIrq |-> epIrq;
  endproperty
  a_xfer_sub: assert property (p_xfer_sub) else $error("transfer irq alone");
endmodule : usb_endpoint_rx_state_checker

// ---- usb_ep_match_if.sv ----
/*
  Carrier between the endpoint block and its token matcher.
  Assumes the owner drives all token and table fields combinationally.
*/
interface usb_ep_match_if;
  import usb_ep_rx_pkg::*;

  logic [EP_COUNT-1:0][EP_IDX_W-1:0] epAddr;
  logic [EP_IDX_W-1:0]               tokEp;
  logic [DEV_ADDR_W-1:0]             tokDev;
  logic [DEV_ADDR_W-1:0]             devAddr;
  logic                              funcEn;
  logic                              hit;
  logic [EP_IDX_W-1:0]               hitIdx;

  modport owner (output epAddr, tokEp, tokDev, devAddr, funcEn,
                 input hit, hitIdx);
  modport matcher (input epAddr, tokEp, tokDev, devAddr, funcEn,
                   output hit, hitIdx);
endinterface : usb_ep_match_if

// ---- usb_ep_rx_pkg.sv ----
/*
  Constants, field layout and encodings for the endpoint receive-state block.
  Assumes a single clock domain and a 32-bit APB slave port.
*/
// Behaviour
// - Sixteen endpoint registers, each matched to a token by its endpoint address field.
// - Each 16-bit endpoint register resets to zero with the fixed field layout.
// - Bus or forced reset clears endpoint registers except both done flags.
// - Good OUT or SETUP sets rx done; writing 0 clears, 1 keeps.
// - Rx done raises endpoint condition; transfer condition too when masked in.
// - NAK, STALL, errors or non-isochronous toggle mismatch never set rx done.
// - Rx toggle holds expected data PID; inverts on ACK of matching packet.
// - A SETUP PID on a control endpoint clears rx toggle.
// - Isochronous rx toggle selects buffer, inverts after every reception while rx handshake state is valid.
// - Writing 1 to rx toggle inverts it, writing 0 keeps it.
// - Each rx handshake bit inverts on written 1, keeps on 0.
// - Good non-isochronous reception moves rx handshake state to NAK.
// - Isochronous handshake state is never changed by hardware.
// - Setup flag shows whether last completed control transaction was SETUP.
// - Setup flag is frozen while rx done is 1.
// - Endpoint handles token only on device and endpoint address match.
// - With function enable low no transaction is handled.
package usb_ep_rx_pkg;

  localparam int EP_COUNT   = 16;
  localparam int EP_IDX_W   = 4;
  localparam int REG_W      = 16;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int DEV_ADDR_W = 7;
  localparam int WORD_LSB_W = 2;

  // Byte addresses of the register map
  localparam logic [ADDR_W-1:0] EP_LAST_ADDR = 8'h3C;
  localparam logic [ADDR_W-1:0] CTRL_ADDR    = 8'h40;
  localparam logic [ADDR_W-1:0] STAT_ADDR    = 8'h44;
  localparam logic [ADDR_W-1:0] FADDR_ADDR   = 8'h4C;

  // Endpoint register layout
  localparam int RX_DONE_BIT = 15;
  localparam int RX_TOG_BIT  = 14;
  localparam int RX_HS_HI    = 13;
  localparam int RX_HS_LO    = 12;
  localparam int SETUP_BIT   = 11;
  localparam int CAT_HI      = 10;
  localparam int CAT_LO      = 9;
  localparam int EP_ADDR_HI  = 3;
  localparam int EP_ADDR_LO  = 0;

  typedef logic [REG_W-1:0] ep_reg_t;

  localparam ep_reg_t EP_RESET     = 16'h0000;
  localparam ep_reg_t EP_KEEP_MASK = 16'h8080;
  localparam ep_reg_t EP_W0C_MASK  = 16'h8080;
  localparam ep_reg_t EP_TOG_MASK  = 16'h7070;
  localparam ep_reg_t EP_RW_MASK   = 16'h070F;

  // Handshake state codes
  localparam logic [1:0] HS_DISABLED = 2'h0;
  localparam logic [1:0] HS_STALL    = 2'h1;
  localparam logic [1:0] HS_NAK      = 2'h2;
  localparam logic [1:0] HS_VALID    = 2'h3;

  // Endpoint categories
  localparam logic [1:0] CAT_BULK    = 2'h0;
  localparam logic [1:0] CAT_CONTROL = 2'h1;
  localparam logic [1:0] CAT_ISO     = 2'h2;
  localparam logic [1:0] CAT_INTR    = 2'h3;

  // Control, status and function address fields
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_MASK_BIT  = 15;
  localparam int STAT_REPLY_LO  = 0;
  localparam int STAT_EP_LO     = 4;
  localparam int STAT_HIT_BIT   = 8;
  localparam int FUNC_EN_BIT    = 7;

  // Handshake reply sent back for a reception
  typedef enum logic [1:0] {
    REPLY_NONE  = 2'h0,
    REPLY_ACK   = 2'h1,
    REPLY_NAK   = 2'h2,
    REPLY_STALL = 2'h3
  } reply_t;

endpackage : usb_ep_rx_pkg

// ---- usb_ep_token_match.sv ----
/*
  Token matcher: finds the endpoint register addressed by a token.
  Assumes the table and token fields are stable within the cycle.
*/
module usb_ep_token_match
  import usb_ep_rx_pkg::*;
(
  usb_ep_match_if.matcher bus
);

  // Lowest matching endpoint wins
  function automatic logic [EP_IDX_W:0] pickLowest(
    input logic [EP_COUNT-1:0] req);
    logic [EP_IDX_W:0] r;
    r = '0;
    for (int i = EP_COUNT - 1; i >= 0; i--) begin
      if (req[i]) begin
        r = {1'b1, EP_IDX_W'(i)};
      end
    end
    return r;
  endfunction : pickLowest

  logic [EP_COUNT-1:0] epHit;
  logic [EP_IDX_W:0]   pick;

  // Per-endpoint address compare
  genvar g;
  generate
    for (g = 0; g < EP_COUNT; g++) begin : g_cmp
      assign epHit[g] = bus.epAddr[g] == bus.tokEp;
    end
  endgenerate

  // Device address and function enable gate
  always_comb begin
    pick       = pickLowest(epHit);
    bus.hit    = bus.funcEn && (bus.tokDev == bus.devAddr)
                 && pick[EP_IDX_W];
    bus.hitIdx = pick[EP_IDX_W-1:0];
  end

endmodule : usb_ep_token_match

// ---- usb_host_model.sv ----
/* Behavioural host and link engine: one finished OUT or SETUP data
   phase per send call. Assumes the bench calls send from one process. */
module usb_host_model
  import usb_ep_rx_pkg::*;
(
  input  wire logic              clk,
  output logic                   rxEnd,
  output logic                   rxIsSetup,
  output logic [DEV_ADDR_W-1:0]  rxDevAddr,
  output logic [EP_IDX_W-1:0]    rxEpNum,
  output logic                   rxDataPid,
  output logic                   rxError
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet link at start
  initial begin
    rxEnd = 1'b0;
    rxIsSetup = 1'b0;
    rxDevAddr = 7'h00;
    rxEpNum = 4'h0;
    rxDataPid = 1'b0;
    rxError = 1'b0;
  end
  // One-cycle end pulse, fields scrambled once it drops
  task automatic send(input logic s, input logic [DEV_ADDR_W-1:0] dv,
                      input logic [EP_IDX_W-1:0] ep, input logic pid, input logic er);
    @(posedge clk);
    rxEnd <= 1'b1;
    rxIsSetup <= s;
    rxDevAddr <= dv;
    rxEpNum <= ep;
    rxDataPid <= pid;
    rxError <= er;
    @(posedge clk);
    rxEnd <= 1'b0;
    rxIsSetup <= ~s;
    rxDevAddr <= ~dv;
    rxEpNum <= ~ep;
    rxDataPid <= ~pid;
    rxError <= ~er;
  endtask : send
endmodule : usb_host_model
